// ==== design/rct_map.svh ====
// Register map, field positions, reset values and timing figures of the
// calibration and test register bank. Definitions only; included by bare name.
`ifndef RCT_MAP_SVH
`define RCT_MAP_SVH

// Register indices; the byte address is four times the index.
`define RCT_IDX_CAL          10'h055
`define RCT_IDX_MODEM        10'h056
`define RCT_IDX_CPTEST       10'h057
`define RCT_IDX_CPTRIM       10'h058

// Calibration control fields.
`define RCT_CAL_XHALF        6
`define RCT_CAL_FINE         4
`define RCT_CAL_RCCAL        3
`define RCT_CAL_VCODP        2
`define RCT_CAL_VCOCAL       1
`define RCT_CAL_SKIP         0

// Charge-pump trim fields.
`define RCT_TRIM_CURR_HI     7
`define RCT_TRIM_CURR_LO     6
`define RCT_TRIM_OV          5
`define RCT_TRIM_CORR_HI     4

// Reset values.
`define RCT_CAL_RST          8'h44
`define RCT_MODEM_RST        8'h00
`define RCT_CPTEST_RST       8'h00
`define RCT_CURR_RST         2'h2
`define RCT_CORR_RST         5'h00

// Timing figures in their own units and the clock rate.
`define RCT_RC_CAL_US        2000
`define RCT_FINE_PERIOD_S    30
`define RCT_CLK_KHZ          25000

`endif

// ==== design/rct_pkg.sv ====
// Types shared by the calibration and test register bank.
// Takes nothing from rct_map.svh; the state encodings are defined here.
package rct_pkg;

    typedef struct packed {
        logic xtal_half;
        logic rc_fine_en;
        logic vco_dp;
        logic skip_vco;
    } rct_cal_ctrl_s;

    typedef struct packed {
        logic bcr_comp_byp;
        logic slicer_comp_byp;
        logic dither_pm1_only;
        logic osc_det_dis;
        logic ook_th_8bit;
        logic ref_10mhz;
        logic ref_inv;
        logic disc_toggle_en;
    } rct_modem_s;

    typedef struct packed {
        logic       pfd_reset;
        logic       fbdiv_reset;
        logic       cp_force_up;
        logic       cp_force_dn;
        logic       cp_dc_only;
        logic [2:0] cp_dc_curr;
    } rct_cp_test_s;

    typedef enum logic [1:0] {
        RCT_RC_IDLE = 2'b01,
        RCT_RC_RUN  = 2'b10
    } rct_rc_state_e;

endpackage

// ==== design/rct_regs.sv ====
// APB register bank for the transmitter calibration and synthesizer test
// controls, with RC-oscillator calibration sequencing.
// Assumes every status input comes from logic on pclk and an APB master.
`timescale 1ns/1ps
`include "rct_map.svh"

// Functional notes
// - Writing RC trigger bit from zero to one starts calibration; bit self-clears.
// - Forced RC calibration lasts a fixed two milliseconds.
// - Wake-up timer enable calibrates the RC oscillator automatically.
// - With fine enable set, RC fine calibration repeats about every 30 s.
// - Crystal half-start bit halves the crystal wake-up wait.
// - VCO trigger in idle with synthesizer on runs one calibration, self-clears.
// - Double-precision bit lengthens the VCO calibration measurement.
// - Skip bit omits VCO calibration going from idle to transmit.
// - Bypass bit bypasses bit clock recovery phase compensation.
// - Slicer bypass bit bypasses slicer phase compensation.
// - Dither type low adds plus/minus one or zero; high adds plus/minus one.
// - Oscillation-detect bit low keeps ADC detection on; one disables it.
// - OOK slicer threshold over 8 preamble bits when set, else 4.
// - Reference select picks 10 MHz or synthesizer; another bit inverts it.
// - Discriminator toggle bit zero disables discriminator toggling.
// - Two bits force the charge pump continuously up or down.
// - Correction field read returns the value the charge pump uses.
// - With override set, written correction drives the pump and reads back.
// - Correction field is all zeros at power-up.
// - Three-bit field selects DC current; one bit forces DC offset only.
module rct_regs #(
    parameter int ADDR_W     = 12,
    parameter int RC_CAL_CYC = `RCT_RC_CAL_US * `RCT_CLK_KHZ / 1000,
    parameter int FINE_CYC   = `RCT_FINE_PERIOD_S * `RCT_CLK_KHZ * 1000
) (
    input  wire logic                  pclk,
    input  wire logic                  presetn,
    input  wire logic                  psel,
    input  wire logic                  penable,
    input  wire logic                  pwrite,
    input  wire logic [ADDR_W-1:0]     paddr,
    input  wire logic [31:0]           pwdata,
    output logic                       pready,
    output logic [31:0]                prdata,
    output logic                       pslverr,
    input  wire logic                  rc_osc_en,
    input  wire logic                  wut_en,
    input  wire logic                  sys_idle,
    input  wire logic                  pll_on,
    input  wire logic                  vco_cal_done,
    input  wire logic [4:0]            cp_corr_auto,
    output logic                       rc_cal_run,
    output logic                       vco_cal_run,
    output rct_pkg::rct_cal_ctrl_s     cal_ctrl,
    output rct_pkg::rct_modem_s        modem_ctrl,
    output rct_pkg::rct_cp_test_s      cp_test,
    output logic [1:0]                 cp_curr,
    output logic [4:0]                 cp_corr
);
    import rct_pkg::*;

    // Reset image of the calibration control register, taken apart bit by bit below.
    localparam logic [7:0] CAL_RST = `RCT_CAL_RST;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [9:0] idx);
        hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(idx)) && (a[1:0] == 2'h0);
    endfunction

    logic                 pready_reg;
    logic [31:0]          prdata_reg;
    logic                 pslverr_reg;
    logic                 xhalf_reg;
    logic                 fine_reg;
    logic                 vcodp_reg;
    logic                 skip_reg;
    logic                 vco_run_reg;
    rct_rc_state_e        rc_state_reg;
    rct_rc_state_e        rc_state_next;
    logic [31:0]          rc_cnt_reg;
    logic [31:0]          fine_cnt_reg;
    logic                 wut_d_reg;
    rct_modem_s           modem_reg;
    rct_cp_test_s         cptest_reg;
    logic [1:0]           curr_reg;
    logic                 ov_reg;
    logic [4:0]           corr_reg;
    logic [4:0]           corr_out_reg;

    wire sel_cal    = hit(paddr, `RCT_IDX_CAL);
    wire sel_modem  = hit(paddr, `RCT_IDX_MODEM);
    wire sel_cptest = hit(paddr, `RCT_IDX_CPTEST);
    wire sel_cptrim = hit(paddr, `RCT_IDX_CPTRIM);
    wire sel_any    = sel_cal | sel_modem | sel_cptest | sel_cptrim;
    wire setup      = psel & ~penable;
    wire wr         = psel & penable & pready_reg & pwrite & ~pslverr_reg;
    wire wr_cal     = wr & sel_cal;
    wire wr_trim    = wr & sel_cptrim;

    // ----------------------------------------------------------------
    // RC-oscillator calibration sequencing
    // ----------------------------------------------------------------
    wire rc_idle     = (rc_state_reg == RCT_RC_IDLE);
    wire sw_rc_req   = wr_cal & pwdata[`RCT_CAL_RCCAL];
    wire wut_rise    = wut_en & ~wut_d_reg;
    wire fine_expire = fine_reg & (fine_cnt_reg == 32'(FINE_CYC - 1));
    wire rc_start    = rc_idle & rc_osc_en & (sw_rc_req | wut_rise | fine_expire);
    wire rc_last     = (rc_cnt_reg == 32'(RC_CAL_CYC - 1));

    always_comb begin
        rc_state_next = rc_state_reg;
        case (rc_state_reg)
            RCT_RC_IDLE: begin
                if (rc_start) begin
                    rc_state_next = RCT_RC_RUN;
                end
            end
            RCT_RC_RUN: begin
                if (rc_last) begin
                    rc_state_next = RCT_RC_IDLE;
                end
            end
            default: rc_state_next = RCT_RC_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rc_state_reg <= RCT_RC_IDLE;
            rc_cnt_reg   <= 32'h0000_0000;
            wut_d_reg    <= 1'b0;
        end else begin
            rc_state_reg <= rc_state_next;
            rc_cnt_reg   <= (rc_idle | rc_last) ? 32'h0000_0000 : rc_cnt_reg + 32'h1;
            wut_d_reg    <= wut_en;
        end
    end

    // Fine timer runs only while fine calibration is enabled and the
    // oscillator is up; it restarts after every expiry.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fine_cnt_reg <= 32'h0000_0000;
        end else if (!fine_reg || !rc_osc_en || fine_expire) begin
            fine_cnt_reg <= 32'h0000_0000;
        end else begin
            fine_cnt_reg <= fine_cnt_reg + 32'h1;
        end
    end

    // ----------------------------------------------------------------
    // VCO calibration trigger
    // ----------------------------------------------------------------
    wire vco_start = wr_cal & pwdata[`RCT_CAL_VCOCAL] & sys_idle & pll_on & ~vco_run_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            vco_run_reg <= 1'b0;
        end else if (vco_start) begin
            vco_run_reg <= 1'b1;
        end else if (vco_cal_done) begin
            vco_run_reg <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // Software registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xhalf_reg <= CAL_RST[`RCT_CAL_XHALF];
            fine_reg  <= CAL_RST[`RCT_CAL_FINE];
            vcodp_reg <= CAL_RST[`RCT_CAL_VCODP];
            skip_reg  <= CAL_RST[`RCT_CAL_SKIP];
        end else if (wr_cal) begin
            xhalf_reg <= pwdata[`RCT_CAL_XHALF];
            fine_reg  <= pwdata[`RCT_CAL_FINE];
            vcodp_reg <= pwdata[`RCT_CAL_VCODP];
            skip_reg  <= pwdata[`RCT_CAL_SKIP];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            modem_reg  <= `RCT_MODEM_RST;
            cptest_reg <= `RCT_CPTEST_RST;
        end else begin
            if (wr & sel_modem) begin
                modem_reg <= pwdata[7:0];
            end
            if (wr & sel_cptest) begin
                cptest_reg <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------------------------------
    // Charge-pump correction override
    // ----------------------------------------------------------------
    wire [4:0] corr_next = ov_reg ? corr_reg : cp_corr_auto;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            curr_reg     <= `RCT_CURR_RST;
            ov_reg       <= 1'b0;
            corr_reg     <= `RCT_CORR_RST;
            corr_out_reg <= `RCT_CORR_RST;
        end else begin
            if (wr_trim) begin
                curr_reg <= pwdata[`RCT_TRIM_CURR_HI:`RCT_TRIM_CURR_LO];
                ov_reg   <= pwdata[`RCT_TRIM_OV];
                corr_reg <= pwdata[`RCT_TRIM_CORR_HI:0];
            end
            corr_out_reg <= corr_next;
        end
    end

    // ----------------------------------------------------------------
    // Read path and APB answer
    // ----------------------------------------------------------------
    wire [7:0] cal_rd  = {1'b0, xhalf_reg, 1'b0, fine_reg, ~rc_idle, vcodp_reg,
                          vco_run_reg, skip_reg};
    wire [7:0] trim_rd = {curr_reg, ov_reg, corr_out_reg};
    wire [7:0] rd_mux  = sel_cal    ? cal_rd :
                         sel_modem  ? modem_reg :
                         sel_cptest ? cptest_reg :
                         sel_cptrim ? trim_rd : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            prdata_reg  <= 32'h0000_0000;
            pslverr_reg <= 1'b0;
        end else begin
            pready_reg  <= setup;
            prdata_reg  <= (setup & ~pwrite) ? {24'h00_0000, rd_mux} : 32'h0000_0000;
            pslverr_reg <= setup & ~sel_any;
        end
    end

    assign pready      = pready_reg;
    assign prdata      = prdata_reg;
    assign pslverr     = pslverr_reg;
    assign rc_cal_run  = ~rc_idle;
    assign vco_cal_run = vco_run_reg;
    assign cal_ctrl    = '{xtal_half: xhalf_reg, rc_fine_en: fine_reg,
                           vco_dp: vcodp_reg, skip_vco: skip_reg};
    assign modem_ctrl  = modem_reg;
    assign cp_test     = cptest_reg;
    assign cp_curr     = curr_reg;
    assign cp_corr     = corr_out_reg;

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rc_start;
        rc_idle && rc_osc_en && sw_rc_req |=> rc_cal_run ##1 rc_cal_run;
    endproperty
    a_rc_start: assert property (p_rc_start) else $error("RC calibration did not start");

    property p_rc_len;
        $fell(rc_cal_run) |-> $past(rc_cnt_reg) == 32'(RC_CAL_CYC - 1);
    endproperty
    a_rc_len: assert property (p_rc_len) else $error("RC calibration length wrong");

    property p_rc_osc;
        $rose(rc_cal_run) |-> $past(rc_osc_en);
    endproperty
    a_rc_osc: assert property (p_rc_osc) else $error("RC calibration without oscillator");

    property p_wut;
        wut_en && !wut_d_reg && rc_idle && rc_osc_en |=> rc_cal_run;
    endproperty
    a_wut: assert property (p_wut) else $error("Wake-up timer did not calibrate");

    property p_fine;
        fine_expire && rc_idle && rc_osc_en |=> rc_cal_run && fine_cnt_reg == 32'h0;
    endproperty
    a_fine: assert property (p_fine) else $error("Periodic fine calibration missed");

    property p_vco;
        vco_start |=> vco_cal_run;
    endproperty
    a_vco: assert property (p_vco) else $error("VCO calibration did not start");

    property p_vco_guard;
        $rose(vco_cal_run) |-> $past(sys_idle) && $past(pll_on);
    endproperty
    a_vco_guard: assert property (p_vco_guard) else $error("VCO calibration out of idle");

    property p_ov;
        ov_reg && $stable(ov_reg) |=> cp_corr == $past(corr_reg);
    endproperty
    a_ov: assert property (p_ov) else $error("Override value not applied");

    property p_auto;
        !ov_reg |=> cp_corr == $past(cp_corr_auto) || ov_reg;
    endproperty
    a_auto: assert property (p_auto) else $error("Applied correction not followed");

    property p_resv;
        setup && !pwrite && sel_cal |=> prdata[7] == 1'b0 && prdata[5] == 1'b0;
    endproperty
    a_resv: assert property (p_resv) else $error("Reserved bits read nonzero");

    property p_skip;
        wr_cal |=> cal_ctrl.skip_vco == $past(pwdata[`RCT_CAL_SKIP]) &&
                   cal_ctrl.xtal_half == $past(pwdata[`RCT_CAL_XHALF]);
    endproperty
    a_skip: assert property (p_skip) else $error("Calibration options not stored");

    property p_apb;
        setup |=> pready ##1 !pready;
    endproperty
    a_apb: assert property (p_apb) else $error("APB answer timing wrong");

    property p_rc_refuse;
        rc_idle && !rc_osc_en && sw_rc_req |=> !rc_cal_run;
    endproperty
    a_rc_refuse: assert property (p_rc_refuse) else $error("RC calibration while off");

    property p_vco_done;
        vco_cal_done && !vco_start |=> !vco_cal_run;
    endproperty
    a_vco_done: assert property (p_vco_done) else $error("VCO busy after done");

    property p_modem;
        wr && sel_modem |=> modem_ctrl == $past(pwdata[7:0]);
    endproperty
    a_modem: assert property (p_modem) else $error("Modem test bits not stored");

    property p_cptest;
        wr && sel_cptest |=> cp_test == $past(pwdata[7:0]);
    endproperty
    a_cptest: assert property (p_cptest) else $error("Charge pump test bits not stored");

    property p_corr_rd;
        setup && !pwrite && sel_cptrim |=> prdata[`RCT_TRIM_CORR_HI:0] == $past(cp_corr);
    endproperty
    a_corr_rd: assert property (p_corr_rd) else $error("Correction readback wrong");

endmodule

// ==== tb/tb_rct_regs.sv ====
// Self-checking bench for the calibration and test register bank.
// Assumes the design files and rct_map.svh are compiled first.
`timescale 1ns/1ps
`include "rct_map.svh"

module tb_rct_regs;
    import rct_pkg::*;

    // ------------------------------------------------------------------
    // Signals and instance
    // ------------------------------------------------------------------
    localparam int RC_N = 20;
    localparam int FN_N = 50;

    logic          pclk = 1'b0;
    logic          presetn, psel, penable, pwrite, pready, pslverr;
    logic [11:0]   paddr;
    logic [31:0]   pwdata, prdata;
    logic          rc_osc_en, wut_en, sys_idle, pll_on, vco_cal_done;
    logic          rc_cal_run, vco_cal_run;
    logic [4:0]    cp_corr_auto, cp_corr;
    logic [1:0]    cp_curr;
    rct_cal_ctrl_s cal_ctrl;
    rct_modem_s    modem_ctrl;
    rct_cp_test_s  cp_test;
    int            err_total = 0;
    int            compares = 0;
    int            n;
    logic [31:0]   rd;
    logic          er;

    always #20 pclk = ~pclk;

    rct_regs #(.RC_CAL_CYC(RC_N), .FINE_CYC(FN_N)) i_rct_regs (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .rc_osc_en(rc_osc_en),
        .wut_en(wut_en), .sys_idle(sys_idle), .pll_on(pll_on),
        .vco_cal_done(vco_cal_done), .cp_corr_auto(cp_corr_auto),
        .rc_cal_run(rc_cal_run), .vco_cal_run(vco_cal_run),
        .cal_ctrl(cal_ctrl), .modem_ctrl(modem_ctrl), .cp_test(cp_test),
        .cp_curr(cp_curr), .cp_corr(cp_corr)
    );

    // ------------------------------------------------------------------
    // Tasks
    // ------------------------------------------------------------------
    task automatic print_verdict();
        $display("Compares %0d, mismatches %0d", compares, err_total);
        if (err_total == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // One APB transfer; the request stands until pready is sampled high.
    task automatic apb(input logic [9:0] idx, input logic wr, input logic [31:0] wd,
                       output logic [31:0] rdv, output logic erv);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 20);
        if (pready !== 1'b1) begin
            err_total++;
            print_verdict();
        end
        rdv = prdata;
        erv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
        apb(idx, 1'b1, wd, rd, er);
    endtask

    task automatic rchk(input logic [9:0] idx, input logic [31:0] exp);
        apb(idx, 1'b0, 32'h0, rd, er);
        chk($sformatf("reg %0h", idx), rd, exp);
    endtask

    // Counts rising edges until the calibration flag reaches a level.
    task automatic wait_rc(input logic lvl, output int cnt);
        cnt = 0;
        @(posedge pclk);
        while (rc_cal_run !== lvl) begin
            cnt++;
            if (cnt > 200) begin
                err_total++;
                print_verdict();
            end
            @(posedge pclk);
        end
    endtask

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        {rc_osc_en, wut_en, sys_idle, pll_on, vco_cal_done} = '0;
        cp_corr_auto = 5'h0A;
        repeat (20) @(posedge pclk);
        chk("cp_corr_rst", 32'(cp_corr), 32'h0);
        presetn <= 1'b1;
        rchk(`RCT_IDX_CAL, 32'h44);
        rchk(`RCT_IDX_MODEM, 32'h0);
        rchk(`RCT_IDX_CPTEST, 32'h0);
        rchk(`RCT_IDX_CPTRIM, 32'h8A);
        wr(`RCT_IDX_CAL, 32'hFF);
        rchk(`RCT_IDX_CAL, 32'h55);
        chk("cal_ctrl", 32'(cal_ctrl), 32'hF);
        chk("rc_guard", 32'(rc_cal_run), 32'h0);
        wr(`RCT_IDX_CAL, 32'h0);
        rchk(`RCT_IDX_CAL, 32'h0);
        for (int i = 0; i < 8; i++) begin
            wr(`RCT_IDX_MODEM, 32'h1 << i);
            rchk(`RCT_IDX_MODEM, 32'h1 << i);
            chk("modem_ctrl", 32'(modem_ctrl), 32'h1 << i);
            wr(`RCT_IDX_CPTEST, 32'h1 << i);
            rchk(`RCT_IDX_CPTEST, 32'h1 << i);
            chk("cp_test", 32'(cp_test), 32'h1 << i);
        end
        @(posedge pclk);
        rc_osc_en <= 1'b1;
        wr(`RCT_IDX_CAL, 32'h08);
        wait_rc(1'b0, n);
        chk("rc_cal_len", 32'(n), 32'(RC_N));
        rchk(`RCT_IDX_CAL, 32'h0);
        wut_en <= 1'b1;
        wait_rc(1'b1, n);
        chk("wut_start", 32'(n < 5), 32'h1);
        wait_rc(1'b0, n);
        wut_en <= 1'b0;
        wr(`RCT_IDX_CAL, 32'h10);
        wait_rc(1'b1, n);
        chk("fine_period", 32'(n >= FN_N - 3 && n <= FN_N + 3), 32'h1);
        wait_rc(1'b0, n);
        wr(`RCT_IDX_CAL, 32'h0);
        @(posedge pclk);
        sys_idle <= 1'b1;
        wr(`RCT_IDX_CAL, 32'h02);
        rchk(`RCT_IDX_CAL, 32'h0);
        pll_on <= 1'b1;
        wr(`RCT_IDX_CAL, 32'h02);
        rchk(`RCT_IDX_CAL, 32'h02);
        chk("vco_run", 32'(vco_cal_run), 32'h1);
        vco_cal_done <= 1'b1;
        @(posedge pclk);
        vco_cal_done <= 1'b0;
        rchk(`RCT_IDX_CAL, 32'h0);
        wr(`RCT_IDX_CPTRIM, 32'h45);
        rchk(`RCT_IDX_CPTRIM, 32'h4A);
        chk("cp_curr", 32'(cp_curr), 32'h1);
        cp_corr_auto <= 5'h11;
        repeat (2) @(posedge pclk);
        chk("cp_corr", 32'(cp_corr), 32'h11);
        wr(`RCT_IDX_CPTRIM, 32'h73);
        cp_corr_auto <= 5'h03;
        rchk(`RCT_IDX_CPTRIM, 32'h73);
        chk("cp_corr_ov", 32'(cp_corr), 32'h13);
        apb(10'h059, 1'b0, 32'h0, rd, er);
        chk("unmapped_err", 32'(er), 32'h1);
        chk("unmapped_data", rd, 32'h0);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("cp_corr_rst2", 32'(cp_corr), 32'h0);
        presetn <= 1'b1;
        rchk(`RCT_IDX_CAL, 32'h44);
        rchk(`RCT_IDX_CPTRIM, 32'h83);
        print_verdict();
    end
endmodule
